// file: common/fla_pkg.sv
// Purpose: shared constants for the feedback loop assignment block
// Assumes: 200 MHz ref_clk, three feedback entries (sensorless, hall, encoder)
// Notes: times are given in their own unit, cycle counts derived from them
package fla_pkg;
  // ------------------------------------------------------------
  // clock and timing
  // ------------------------------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int CYCLE_TIME_US = 1;
  localparam int CYCLE_CLKS = CYCLE_TIME_US * CLK_MHZ;
  localparam int ALIGN_TIME_MS = 100;
  localparam int ALIGN_CLKS = ALIGN_TIME_MS * 1000 * CLK_MHZ;
  // ------------------------------------------------------------
  // feedback entries
  // ------------------------------------------------------------
  localparam int NUM_FB = 3;
  localparam logic [1:0] FB_SENSORLESS = 2'h0;
  localparam logic [1:0] FB_HALL = 2'h1;
  localparam logic [1:0] FB_ENCODER = 2'h2;
  localparam logic [1:0] FB_SCAN_FIRST = 2'h1;
  localparam logic [7:0] MASK_RESET = 8'h00;
  // mask bit positions
  localparam int MB_POS = 0;
  localparam int MB_VEL = 1;
  localparam int MB_COM = 2;
  // ------------------------------------------------------------
  // drive submode select bits
  // ------------------------------------------------------------
  localparam int SM_CLOSED_LOOP = 0;
  localparam int SM_AUTO_ALIGN = 4;
  localparam int SM_SLOW_SPEED = 7;
  localparam logic [7:0] SUBMODE_RESET = 8'h00;
  // ------------------------------------------------------------
  // drive state word
  // ------------------------------------------------------------
  localparam int SW_CLOSED_LOOP = 15;
  localparam logic [15:0] SW_DISABLED = 16'h0040;
  localparam logic [15:0] SW_ALIGNING = 16'h0023;
  localparam logic [15:0] SW_OP_ENABLED = 16'h0027;
  // ------------------------------------------------------------
  // speed estimate and changeover
  // ------------------------------------------------------------
  localparam int LPF_SHIFT = 3;
  localparam logic [31:0] SLOW_SPEED_THR = 32'h0000_0010;
  localparam int HYST_NUM = 110;
  localparam int HYST_DEN = 100;
  localparam logic [31:0] FERR_LIMIT = 32'h0000_0100;
  // ------------------------------------------------------------
  // power sequence states, gray along the usual path
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_DISABLED = 2'h0,
    ST_ALIGN = 2'h1,
    ST_ENABLED = 2'h3
  } fla_state_t;
endpackage

// file: design/fla_enc_sync.sv
// Purpose: synchronise sensor pins and track encoder position
// Assumes: enc_a, enc_b, enc_idx and hall_ok are asynchronous pins
// Notes: index_seen holds until reset, i.e. once per restart
`timescale 1ns/1ps
module fla_enc_sync (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic enc_idx,
  input wire logic hall_ok,
  output logic [31:0] enc_pos_ff,
  output logic index_seen_ff,
  output logic hall_ok_ff
);
  // ------------------------------------------------------------
  // two-stage synchronisers
  // ------------------------------------------------------------
  logic [3:0] meta_ff;
  logic [3:0] sync_ff;
  logic a_prev_ff;
  logic b_prev_ff;
  logic [31:0] nxt_enc_pos;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      meta_ff <= 4'h0;
      sync_ff <= 4'h0;
    end
    else
    begin
      meta_ff <= {hall_ok, enc_idx, enc_b, enc_a};
      sync_ff <= meta_ff;
    end
  end

  // ------------------------------------------------------------
  // quadrature decode, x4
  // ------------------------------------------------------------
  always_comb
  begin
    nxt_enc_pos = enc_pos_ff;
    if ((sync_ff[0] ^ a_prev_ff) && !(sync_ff[1] ^ b_prev_ff))
    begin
      if (sync_ff[0] ^ sync_ff[1])
        nxt_enc_pos = enc_pos_ff + 32'h1;
      else
        nxt_enc_pos = enc_pos_ff - 32'h1;
    end
    else if ((sync_ff[1] ^ b_prev_ff) && !(sync_ff[0] ^ a_prev_ff))
    begin
      if (sync_ff[0] ^ sync_ff[1])
        nxt_enc_pos = enc_pos_ff - 32'h1;
      else
        nxt_enc_pos = enc_pos_ff + 32'h1;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      a_prev_ff <= 1'b0;
      b_prev_ff <= 1'b0;
      enc_pos_ff <= 32'h0;
    end
    else
    begin
      a_prev_ff <= sync_ff[0];
      b_prev_ff <= sync_ff[1];
      enc_pos_ff <= nxt_enc_pos;
    end
  end

  // index seen once since restart; hall considered absolute and aligned
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      index_seen_ff <= 1'b0;
      hall_ok_ff <= 1'b0;
    end
    else
    begin
      index_seen_ff <= index_seen_ff | sync_ff[2];
      hall_ok_ff <= sync_ff[3];
    end
  end
endmodule

// file: design/fla_feedback_assign.sv
// Purpose: feedback-to-loop assignment, closed-loop activation, alignment, slow speed
// Assumes: entry 0 sensorless, 1 hall, 2 incremental encoder; one clock
// Notes: mask entries and submode reached through plain write/read ports
// Notes on behaviour
// - each feedback entry holds mask bits position, velocity, commutation.
// - entry zero is always sensorless; later entries follow physical sensor order.
// - position and velocity loops scan upward from second entry; first set bit wins.
// - two commutation sensors marked: the aligned one is used automatically.
// - hall plus encoder: hall commutates closed-loop until first encoder index.
// - closed-loop needs submode bit 0; auto setup success sets it.
// - absolute commutation sensor gives closed-loop right from power-up.
// - encoder-only commutation stays open-loop until index crossed once or alignment completes.
// - no aligned commutation sensor: align once per restart on first enable, then enable; bit 4 is not read.
// - state word bit 15 shows closed-loop active while operation enabled.
// - slow speed derives speed from position change per cycle, low-pass filtered.
// - slow speed drives constant current, monitors following error, vector control if needed.
// - slow/closed changeover at fixed speed with ten percent hysteresis.
// - at standstill with slow speed enabled, closed-loop operates.
`timescale 1ns/1ps
module fla_feedback_assign #(
  parameter int ALIGN_CYCLES = fla_pkg::ALIGN_CLKS
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic mask_wr,
  input wire logic [1:0] mask_idx,
  input wire logic [7:0] mask_wdata,
  output logic [7:0] mask_rdata_ff,
  input wire logic submode_wr,
  input wire logic [7:0] submode_wdata,
  output logic [7:0] submode_rdata_ff,
  input wire logic autosetup_done,
  input wire logic op_enable_cmd,
  input wire logic op_disable_cmd,
  input wire logic [31:0] pos_demand,
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic enc_idx,
  input wire logic hall_ok,
  output logic [1:0] pos_src_ff,
  output logic [1:0] vel_src_ff,
  output logic [1:0] com_src_ff,
  output logic closed_loop_ff,
  output logic align_active_ff,
  output logic slow_active_ff,
  output logic const_current_ff,
  output logic vector_ctrl_ff,
  output logic [15:0] state_word_ff,
  output logic [31:0] speed_ff
);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // upward scan from the second entry; sensorless when nothing set
  function automatic logic [1:0] scan_loop(input logic [7:0] m [fla_pkg::NUM_FB],
                                           input int bit_no);
    logic [1:0] pick;
    pick = fla_pkg::FB_SENSORLESS;
    for (int i = fla_pkg::NUM_FB - 1; i >= int'(fla_pkg::FB_SCAN_FIRST); i--)
      if (m[i][bit_no])
        pick = 2'(i);
    return pick;
  endfunction

  function automatic logic [31:0] abs32(input logic [31:0] v);
    return v[31] ? (32'h0 - v) : v;
  endfunction

  // ------------------------------------------------------------
  // sensor front end
  // ------------------------------------------------------------
  logic [31:0] enc_pos;
  logic index_seen;
  logic hall_aligned;

  fla_enc_sync u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .enc_a(enc_a),
    .enc_b(enc_b),
    .enc_idx(enc_idx),
    .hall_ok(hall_ok),
    .enc_pos_ff(enc_pos),
    .index_seen_ff(index_seen),
    .hall_ok_ff(hall_aligned)
  );

  // ------------------------------------------------------------
  // mask table and submode register
  // ------------------------------------------------------------
  logic [7:0] mask_ff [fla_pkg::NUM_FB];

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < fla_pkg::NUM_FB; i++)
        mask_ff[i] <= fla_pkg::MASK_RESET;
    end
    else if (mask_wr && (int'(mask_idx) < fla_pkg::NUM_FB))
      mask_ff[mask_idx] <= mask_wdata;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      mask_rdata_ff <= fla_pkg::MASK_RESET;
    else if (int'(mask_idx) < fla_pkg::NUM_FB)
      mask_rdata_ff <= mask_ff[mask_idx];
    else
      mask_rdata_ff <= 8'h00;
  end

  // auto setup completion sets the closed-loop bit; it wins over a write
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      submode_rdata_ff <= fla_pkg::SUBMODE_RESET;
    else
    begin
      if (submode_wr)
        submode_rdata_ff <= submode_wdata;
      if (autosetup_done)
        submode_rdata_ff[fla_pkg::SM_CLOSED_LOOP] <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // commutation source selection
  // ------------------------------------------------------------
  logic align_done_ff;
  logic [fla_pkg::NUM_FB-1:0] aligned;
  logic [1:0] nxt_com_src;
  logic com_ok;

  always_comb
  begin
    aligned = '0;
    aligned[fla_pkg::FB_HALL] = hall_aligned;
    aligned[fla_pkg::FB_ENCODER] = index_seen | align_done_ff;
  end

  // later entries are the finer sensors, so the last marked and aligned one is the better one
  always_comb
  begin
    nxt_com_src = scan_loop(mask_ff, fla_pkg::MB_COM);
    com_ok = 1'b0;
    for (int i = int'(fla_pkg::FB_SCAN_FIRST); i < fla_pkg::NUM_FB; i++)
      if (mask_ff[i][fla_pkg::MB_COM] && aligned[i])
      begin
        nxt_com_src = 2'(i);
        com_ok = 1'b1;
      end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      pos_src_ff <= fla_pkg::FB_SENSORLESS;
      vel_src_ff <= fla_pkg::FB_SENSORLESS;
      com_src_ff <= fla_pkg::FB_SENSORLESS;
    end
    else
    begin
      pos_src_ff <= scan_loop(mask_ff, fla_pkg::MB_POS);
      vel_src_ff <= scan_loop(mask_ff, fla_pkg::MB_VEL);
      com_src_ff <= nxt_com_src;
    end
  end

  // ------------------------------------------------------------
  // power sequence with open-loop alignment
  // ------------------------------------------------------------
  fla_pkg::fla_state_t state_ff;
  fla_pkg::fla_state_t nxt_state;
  logic [31:0] align_cnt_ff;
  logic need_align;

  // alignment runs only if no aligned commutation sensor exists
  assign need_align = !com_ok && !align_done_ff;

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      fla_pkg::ST_DISABLED:
        if (op_enable_cmd)
          nxt_state = need_align ? fla_pkg::ST_ALIGN : fla_pkg::ST_ENABLED;
      fla_pkg::ST_ALIGN:
        if (op_disable_cmd)
          nxt_state = fla_pkg::ST_DISABLED;
        else if (align_cnt_ff == 32'(ALIGN_CYCLES - 1))
          nxt_state = fla_pkg::ST_ENABLED;
      fla_pkg::ST_ENABLED:
        if (op_disable_cmd)
          nxt_state = fla_pkg::ST_DISABLED;
      default:
        nxt_state = fla_pkg::ST_DISABLED;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      state_ff <= fla_pkg::ST_DISABLED;
    else
      state_ff <= nxt_state;
  end

  // alignment holds for the rest of the run; cleared only by restart
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      align_cnt_ff <= 32'h0;
      align_done_ff <= 1'b0;
    end
    else if (state_ff == fla_pkg::ST_ALIGN)
    begin
      align_cnt_ff <= align_cnt_ff + 32'h1;
      if (nxt_state == fla_pkg::ST_ENABLED)
        align_done_ff <= 1'b1;
    end
    else
      align_cnt_ff <= 32'h0;
  end

  // ------------------------------------------------------------
  // speed estimate per control cycle
  // ------------------------------------------------------------
  logic [15:0] cyc_cnt_ff;
  logic [31:0] pos_last_ff;
  logic [31:0] raw_speed_ff;
  logic cyc_tick;

  assign cyc_tick = (cyc_cnt_ff == 16'(fla_pkg::CYCLE_CLKS - 1));

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      cyc_cnt_ff <= 16'h0;
      pos_last_ff <= 32'h0;
      raw_speed_ff <= 32'h0;
    end
    else if (cyc_tick)
    begin
      cyc_cnt_ff <= 16'h0;
      pos_last_ff <= enc_pos;
      raw_speed_ff <= enc_pos - pos_last_ff;
    end
    else
      cyc_cnt_ff <= cyc_cnt_ff + 16'h1;
  end

  // first-order low-pass; trades lag for fewer peaks at low speed
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      speed_ff <= 32'h0;
    else if (cyc_tick)
      speed_ff <= speed_ff + 32'($signed(raw_speed_ff - speed_ff) >>> fla_pkg::LPF_SHIFT);
  end

  // ------------------------------------------------------------
  // slow speed changeover and loop activity
  // ------------------------------------------------------------
  localparam logic [31:0] THR_HI =
    32'((64'(fla_pkg::SLOW_SPEED_THR) * fla_pkg::HYST_NUM) / fla_pkg::HYST_DEN);
  logic slow_en;
  logic cl_allowed;
  logic ferr_over;
  logic [31:0] abs_speed;
  logic nxt_slow;

  assign slow_en = submode_rdata_ff[fla_pkg::SM_SLOW_SPEED];
  assign cl_allowed = submode_rdata_ff[fla_pkg::SM_CLOSED_LOOP] && com_ok;
  assign abs_speed = abs32(speed_ff);
  assign ferr_over = abs32(pos_demand - enc_pos) > fla_pkg::FERR_LIMIT;

  always_comb
  begin
    nxt_slow = slow_active_ff;
    if (!slow_en || !cl_allowed || abs_speed == 32'h0)
      nxt_slow = 1'b0;
    else if (abs_speed > THR_HI)
      nxt_slow = 1'b0;
    else if (abs_speed < fla_pkg::SLOW_SPEED_THR)
      nxt_slow = 1'b1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      slow_active_ff <= 1'b0;
      closed_loop_ff <= 1'b0;
      align_active_ff <= 1'b0;
      const_current_ff <= 1'b1;
      vector_ctrl_ff <= 1'b0;
    end
    else
    begin
      slow_active_ff <= nxt_slow;
      closed_loop_ff <= cl_allowed && !nxt_slow;
      align_active_ff <= (state_ff == fla_pkg::ST_ALIGN);
      const_current_ff <= !cl_allowed || nxt_slow;
      vector_ctrl_ff <= cl_allowed && (!nxt_slow || ferr_over);
    end
  end

  // ------------------------------------------------------------
  // state word
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      state_word_ff <= fla_pkg::SW_DISABLED;
    else
    begin
      case (state_ff)
        fla_pkg::ST_ENABLED:
        begin
          state_word_ff <= fla_pkg::SW_OP_ENABLED;
          state_word_ff[fla_pkg::SW_CLOSED_LOOP] <= cl_allowed && !nxt_slow;
        end
        fla_pkg::ST_ALIGN:
          state_word_ff <= fla_pkg::SW_ALIGNING;
        default:
          state_word_ff <= fla_pkg::SW_DISABLED;
      endcase
    end
  end
endmodule

// file: testbench/fla_feedback_assign_properties.sv
// Purpose: port-level checks for the feedback loop assignment block
// Assumes: one clock, synchronous active-high reset
// Notes: alignment length is bounded by a counter, not a long repetition
`timescale 1ns/1ps
module fla_feedback_assign_properties #(
  parameter int ALIGN_CYCLES = 20
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic mask_wr,
  input wire logic [1:0] mask_idx,
  input wire logic [7:0] mask_wdata,
  input wire logic [7:0] mask_rdata_ff,
  input wire logic submode_wr,
  input wire logic [7:0] submode_wdata,
  input wire logic [7:0] submode_rdata_ff,
  input wire logic autosetup_done,
  input wire logic op_enable_cmd,
  input wire logic op_disable_cmd,
  input wire logic [1:0] pos_src_ff,
  input wire logic [1:0] vel_src_ff,
  input wire logic [1:0] com_src_ff,
  input wire logic closed_loop_ff,
  input wire logic align_active_ff,
  input wire logic slow_active_ff,
  input wire logic const_current_ff,
  input wire logic [15:0] state_word_ff
);
  // ------------------------------------------------------------
  // helper logic
  // ------------------------------------------------------------
  int align_cnt_ff;
  always_ff @(posedge ref_clk)
  begin
    if (rst || !align_active_ff)
      align_cnt_ff <= 0;
    else
      align_cnt_ff <= align_cnt_ff + 1;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  reset_values_a: assert property (disable iff (1'b0) rst |=>
    state_word_ff == fla_pkg::SW_DISABLED && const_current_ff) else $error("bad reset values");
  mask_readback_a: assert property ((mask_wr && mask_idx != 2'h3) ##1
    ($stable(mask_idx) && !mask_wr) |=> mask_rdata_ff == $past(mask_wdata, 2))
    else $error("mask readback differs from write");
  spare_index_a: assert property (mask_idx == 2'h3 |=> mask_rdata_ff == 8'h00)
    else $error("unused entry reads non-zero");
  submode_write_a: assert property (submode_wr && !autosetup_done |=>
    submode_rdata_ff == $past(submode_wdata)) else $error("submode write lost");
  setup_sets_a: assert property (autosetup_done |=> submode_rdata_ff[0])
    else $error("auto setup did not set closed-loop enable");
  closed_needs_a: assert property (closed_loop_ff |-> $past(submode_rdata_ff[0]))
    else $error("closed loop without enable bit");
  slow_excl_a: assert property (closed_loop_ff |-> !slow_active_ff)
    else $error("closed loop and slow speed together");
  slow_current_a: assert property (slow_active_ff |-> const_current_ff)
    else $error("slow speed without constant current");
  enable_resp_a: assert property ((op_enable_cmd && !op_disable_cmd &&
    state_word_ff[7:0] == 8'h40) |=> ##1 state_word_ff[7:0] != 8'h40)
    else $error("enable command ignored");
  disable_resp_a: assert property (op_disable_cmd && !op_enable_cmd |=> ##1
    state_word_ff[14:0] == fla_pkg::SW_DISABLED[14:0]) else $error("disable ignored");
  align_word_a: assert property (align_active_ff |->
    state_word_ff[14:0] == fla_pkg::SW_ALIGNING[14:0]) else $error("align word wrong");
  align_hold_a: assert property ($rose(align_active_ff) |-> align_active_ff[*8])
    else $error("alignment cut short");
  align_len_a: assert property (align_cnt_ff <= ALIGN_CYCLES + 2)
    else $error("alignment too long");
  src_range_a: assert property (pos_src_ff != 2'h3 && vel_src_ff != 2'h3 &&
    com_src_ff != 2'h3) else $error("source outside entry range");
  cover property (align_active_ff);
  cover property (closed_loop_ff && state_word_ff[15]);
  cover property (com_src_ff == fla_pkg::FB_ENCODER);
  cover property (slow_active_ff);
endmodule

// file: testbench/fla_feedback_assign_test.sv
// Purpose: directed bench for loop assignment, activation and alignment
// Assumes: inputs change on the falling edge
// Notes: short alignment count keeps the run brief
`timescale 1ns/1ps
module fla_feedback_assign_test;
  localparam int ALIGN_CYCLES = 20;
  logic ref_clk, rst, mask_wr, submode_wr, autosetup_done, op_enable_cmd, op_disable_cmd;
  logic [1:0] mask_idx, pos_src_ff, vel_src_ff, com_src_ff;
  logic [7:0] mask_wdata, submode_wdata, mask_rdata_ff, submode_rdata_ff;
  logic run, hall_on, idx_req, enc_a, enc_b, enc_idx, hall_ok;
  logic closed_loop_ff, align_active_ff, slow_active_ff, const_current_ff, vector_ctrl_ff;
  logic [15:0] state_word_ff;
  logic [31:0] speed_ff, pos_demand;
  logic [7:0] tbl [4];
  int num_errors, checks_done;
  int n_slow;
  fla_feedback_assign #(.ALIGN_CYCLES(ALIGN_CYCLES)) dut_u (.ref_clk(ref_clk), .rst(rst),
    .mask_wr(mask_wr), .mask_idx(mask_idx), .mask_wdata(mask_wdata),
    .mask_rdata_ff(mask_rdata_ff), .submode_wr(submode_wr), .submode_wdata(submode_wdata),
    .submode_rdata_ff(submode_rdata_ff), .autosetup_done(autosetup_done),
    .op_enable_cmd(op_enable_cmd), .op_disable_cmd(op_disable_cmd), .pos_demand(pos_demand),
    .enc_a(enc_a), .enc_b(enc_b), .enc_idx(enc_idx), .hall_ok(hall_ok),
    .pos_src_ff(pos_src_ff), .vel_src_ff(vel_src_ff), .com_src_ff(com_src_ff),
    .closed_loop_ff(closed_loop_ff), .align_active_ff(align_active_ff),
    .slow_active_ff(slow_active_ff), .const_current_ff(const_current_ff),
    .vector_ctrl_ff(vector_ctrl_ff), .state_word_ff(state_word_ff), .speed_ff(speed_ff));
  fla_sensor_model sens_u (.ref_clk(ref_clk), .rst(rst), .run(run), .hall_on(hall_on),
    .idx_req(idx_req), .enc_a(enc_a), .enc_b(enc_b), .enc_idx(enc_idx), .hall_ok(hall_ok));
  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      num_errors++;
    end
  endtask
  task automatic tally_and_finish;
    $display("checks=%0d errors=%0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
    tick(1);
  endtask
  task automatic wr_mask(input logic [1:0] i, input logic [7:0] d);
    mask_idx = i;
    mask_wdata = d;
    pulse(mask_wr);
  endtask
  task automatic rd_mask(input logic [1:0] i, input logic [7:0] exp);
    mask_idx = i;
    tick(2);
    chk(mask_rdata_ff, exp);
  endtask
  task automatic wr_sub(input logic [7:0] d);
    submode_wdata = d;
    pulse(submode_wr);
  endtask
  // bounded wait on the low byte of the state word
  task automatic wait_sw(input logic [7:0] lo, input int bound);
    int n;
    n = 0;
    while (state_word_ff[7:0] !== lo && n < bound)
    begin
      tick(1);
      n++;
    end
    if (state_word_ff[7:0] !== lo)
    begin
      chk(state_word_ff[7:0], lo);
      tally_and_finish();
    end
  endtask
  task automatic do_reset;
    rst = 1'b1;
    run = 1'b0;
    idx_req = 1'b0;
    hall_on = 1'b0;
    tick(3);
    rst = 1'b0;
    tick(1);
  endtask
  task automatic index_pass;
    run = 1'b1;
    idx_req = 1'b1;
    tick(8);
    idx_req = 1'b0;
    run = 1'b0;
    tick(4);
  endtask
  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial
  begin
    {rst, mask_wr, submode_wr, autosetup_done, op_enable_cmd, op_disable_cmd} = 6'h21;
    {run, hall_on, idx_req, mask_idx, mask_wdata, submode_wdata, pos_demand} = '0;
    op_disable_cmd = 1'b0;
    num_errors = 0;
    checks_done = 0;
    tbl = '{8'h00, 8'h06, 8'h07, 8'h07};
    do_reset();
    chk(state_word_ff, fla_pkg::SW_DISABLED);
    chk(const_current_ff, 1'b1);
    chk(submode_rdata_ff, fla_pkg::SUBMODE_RESET);
    rd_mask(2'h2, fla_pkg::MASK_RESET);
    chk({pos_src_ff, vel_src_ff, com_src_ff}, 6'h00);
    $display("test reset done");
    hall_on = 1'b1;
    for (int i = 0; i < 4; i++)
      wr_mask(i[1:0], tbl[i]);
    for (int i = 0; i < 3; i++)
      rd_mask(i[1:0], tbl[i]);
    rd_mask(2'h3, 8'h00);
    tick(6);
    chk(pos_src_ff, fla_pkg::FB_ENCODER);
    chk(vel_src_ff, fla_pkg::FB_HALL);
    chk(com_src_ff, fla_pkg::FB_HALL);
    chk(closed_loop_ff, 1'b0);
    pulse(autosetup_done);
    chk(submode_rdata_ff[0], 1'b1);
    tick(1);
    chk(closed_loop_ff, 1'b1);
    pulse(op_enable_cmd);
    wait_sw(8'h27, 10);
    chk(state_word_ff[15], 1'b1);
    chk(vector_ctrl_ff, 1'b1);
    wr_sub(8'h81);
    tick(4);
    chk({closed_loop_ff, slow_active_ff}, 2'h2);
    index_pass();
    chk(com_src_ff, fla_pkg::FB_ENCODER);
    pulse(op_disable_cmd);
    wait_sw(8'h40, 10);
    $display("test scan done");
    do_reset();
    wr_mask(2'h2, 8'h05);
    wr_sub(8'h01);
    tick(6);
    chk({closed_loop_ff, vector_ctrl_ff}, 2'h0);
    pulse(op_enable_cmd);
    wait_sw(8'h23, 10);
    chk(align_active_ff, 1'b1);
    wait_sw(8'h27, ALIGN_CYCLES + 10);
    tick(2);
    chk(closed_loop_ff, 1'b1);
    pulse(op_disable_cmd);
    wait_sw(8'h40, 10);
    pulse(op_enable_cmd);
    tick(1);
    chk(state_word_ff[7:0], 8'h27);
    $display("test align done");
    do_reset();
    wr_mask(2'h2, 8'h05);
    wr_sub(8'h11);
    index_pass();
    chk(closed_loop_ff, 1'b1);
    $display("test index done");
    // far demand keeps following error over its limit, so slow speed must still use vectors
    pos_demand = 32'h0000_1000;
    wr_sub(8'h81);
    run = 1'b1;
    n_slow = 0;
    repeat (6000)
    begin
      tick(1);
      if (slow_active_ff)
      begin
        n_slow++;
        chk(vector_ctrl_ff, 1'b1);
      end
    end
    chk(n_slow > 0, 1'b1);
    // model counts down one step per four clocks; filter settles on the full step rate
    chk(speed_ff, -(fla_pkg::CYCLE_CLKS / 4));
    chk({closed_loop_ff, slow_active_ff}, 2'h2);
    run = 1'b0;
    $display("test speed done");
    tally_and_finish();
  end
endmodule
bind fla_feedback_assign fla_feedback_assign_properties #(.ALIGN_CYCLES(ALIGN_CYCLES)) chk_u (
  .ref_clk, .rst, .mask_wr, .mask_idx, .mask_wdata, .mask_rdata_ff, .submode_wr,
  .submode_wdata, .submode_rdata_ff, .autosetup_done, .op_enable_cmd, .op_disable_cmd,
  .pos_src_ff, .vel_src_ff, .com_src_ff, .closed_loop_ff, .align_active_ff,
  .slow_active_ff, .const_current_ff, .state_word_ff);

// file: testbench/fla_sensor_model.sv
// Purpose: hall and quadrature encoder stand-in
// Assumes: one quadrature step every four clocks while running
// Notes: pins hold their level when stopped, as a real encoder would
`timescale 1ns/1ps
module fla_sensor_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic run,
  input wire logic hall_on,
  input wire logic idx_req,
  output logic enc_a,
  output logic enc_b,
  output logic enc_idx,
  output logic hall_ok
);
  logic [1:0] div_ff;
  logic [1:0] phase_ff;
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      div_ff <= 2'h0;
    else if (run)
      div_ff <= div_ff + 2'h1;
  end
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      phase_ff <= 2'h0;
    else if (run && div_ff == 2'h3)
      phase_ff <= phase_ff + 2'h1;
  end
  // gray order so only one pin moves per step
  assign enc_a = phase_ff[1];
  assign enc_b = phase_ff[1] ^ phase_ff[0];
  assign enc_idx = idx_req;
  assign hall_ok = hall_on;
endmodule
